//--- verilog/sar_frame_pkg.sv
// constants and carrier types for the sar converter frame control
// assumes a single 100 MHz system clock sampling the host pins synchronously
package sar_frame_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned LEAD_ZEROS = 4;
  localparam int unsigned FRAME_EDGES = 16;
  localparam int unsigned PD_FIRST_EDGE = 2;
  localparam int unsigned PD_LAST_EDGE = 10;
  localparam int unsigned WAKE_MIN_EDGES = 10;
  // power-up time after a wake frame starts
  localparam int unsigned WAKE_TIME_NS = 800;
  localparam int unsigned WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] EDGE_CNT_RESET = 5'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CONV = 3'b001,
    ST_TAIL = 3'b010,
    ST_DOWN = 3'b011,
    ST_WAKE = 3'b100
  } frame_state_t;

  // host-side pin group
  typedef struct packed {
    logic frame_sel_n;
    logic shift_clk;
  } host_pins_t;

  // serial data pin group
  typedef struct packed {
    logic data;
    logic oe_n;
  } serial_pin_t;

endpackage : sar_frame_pkg

//--- verilog/sar_adc_serial_frame_control.sv
// sar converter conversion control and serial readout, one frame per frame select low
// assumes host pins are synchronous to clk_in; edges are found by comparing with last value
// Contract
// - frame select fall samples the input and starts a conversion.
// - 10-bit word: four zeros, ten bits msb first, two zeros.
// - 8-bit word: four zeros, eight bits msb first, four zeros.
// - first zero on select fall, zeros to third edge, msb on fourth.
// - output goes high impedance on the sixteenth falling edge.
// - 10-bit: conversion ends edge 14, acquisition after edge 13.
// - 8-bit: conversion ends edge 12, acquisition after edge 11.
// - select held low until acquisition, else next result invalid.
// - select rise after start aborts conversion, output high impedance.
// - 8-bit short frame may end after edge 12, output released.
// - select rise between edges 2 and 10 enters power-down.
// - dummy frame beyond ten falling edges wakes the device.
// - device needs 0.8 us after wake frame start to power up.
module sar_adc_serial_frame_control #(
  parameter int unsigned RES_BITS = 10, // 10 or 8
  parameter int unsigned WAKE_CYCLES = sar_frame_pkg::WAKE_CYCLES
) (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // async reset, active low
  input wire sar_frame_pkg::host_pins_t host_in, // frame select and shift clock
  input wire logic [RES_BITS-1:0] sample_in, // converter result for the sampled input
  output sar_frame_pkg::serial_pin_t serial_result_out, // data and enable, enable low drives
  output logic [RES_BITS-1:0] result_out, // result sampled at the last conversion start
  output logic result_valid_out, // pulse: conversion ended
  output logic sample_out, // pulse: input sampled
  output logic acquiring_out, // level: acquisition phase
  output logic powered_down_out, // level: in power-down
  output logic ready_out // level: fully powered
);

  localparam int unsigned CONV_END_EDGE = RES_BITS + 4; // 14 or 12
  localparam int unsigned ACQ_EDGE = CONV_END_EDGE - 1; // 13 or 11
  localparam int unsigned LAST_DATA_EDGE = sar_frame_pkg::LEAD_ZEROS + RES_BITS - 1;

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // fall number n launches a result bit
  function automatic logic is_data_edge(input logic [4:0] n);
    is_data_edge = (n >= 5'(sar_frame_pkg::LEAD_ZEROS)) && (n <= 5'(LAST_DATA_EDGE));
  endfunction : is_data_edge

  // select rise after n falls puts the converter to sleep
  function automatic logic is_pd_window(input logic [4:0] n);
    is_pd_window = (n >= 5'(sar_frame_pkg::PD_FIRST_EDGE)) &&
                   (n < 5'(sar_frame_pkg::PD_LAST_EDGE));
  endfunction : is_pd_window

  // enough falls seen in a dummy frame to wake up
  function automatic logic is_wake_count(input logic [4:0] n);
    is_wake_count = n > 5'(sar_frame_pkg::WAKE_MIN_EDGES);
  endfunction : is_wake_count

  // converter still asleep: down, or inside the wake frame
  function automatic logic is_down(input sar_frame_pkg::frame_state_t s);
    is_down = (s == sar_frame_pkg::ST_DOWN) || (s == sar_frame_pkg::ST_WAKE);
  endfunction : is_down

  ////////////////////////////////////////////////////////////////////////////
  // pin edge detection

  logic sel_n_q, sclk_q;
  logic sel_n_d, sclk_d;
  logic sel_fall, sel_rise, sclk_fall, sclk_rise;

  always_comb begin
    sel_n_d = host_in.frame_sel_n;
    sclk_d = host_in.shift_clk;
  end

  // reset values match the idle pin levels, so no false edge after reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_n_q <= 1'b1;
      sclk_q <= 1'b1;
    end else begin
      sel_n_q <= sel_n_d;
      sclk_q <= sclk_d;
    end
  end

  always_comb begin
    sel_fall = sel_n_q && !host_in.frame_sel_n;
    sel_rise = !sel_n_q && host_in.frame_sel_n;
    sclk_fall = sclk_q && !host_in.shift_clk && !host_in.frame_sel_n;
    sclk_rise = !sclk_q && host_in.shift_clk && !host_in.frame_sel_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame state machine

  sar_frame_pkg::frame_state_t state_q, state_d;
  logic [4:0] edge_q, edge_d;
  logic [RES_BITS-1:0] shreg_q, shreg_d;
  logic [RES_BITS-1:0] res_q, res_d;
  logic valid_q, valid_d;
  logic acq_q, acq_d;
  logic acq_pend_q, acq_pend_d;
  logic data_q, data_d;
  logic oe_n_q, oe_n_d;
  logic [15:0] wake_q, wake_d;
  logic smp_d, smp_q;
  logic wake_load;
  logic [4:0] edge_inc;

  always_comb begin
    edge_inc = edge_q + 5'h01;
  end

  always_comb begin
    state_d = state_q;
    edge_d = edge_q;
    shreg_d = shreg_q;
    valid_d = 1'b0;
    acq_d = acq_q;
    acq_pend_d = acq_pend_q;
    data_d = data_q;
    oe_n_d = oe_n_q;
    wake_load = 1'b0;
    smp_d = 1'b0;
    case (state_q)
      sar_frame_pkg::ST_IDLE, sar_frame_pkg::ST_DOWN: begin
        if (sel_fall) begin
          edge_d = sar_frame_pkg::EDGE_CNT_RESET;
          data_d = 1'b0;
          oe_n_d = 1'b0;
          acq_pend_d = 1'b0;
          if (state_q == sar_frame_pkg::ST_DOWN) begin
            state_d = sar_frame_pkg::ST_WAKE;
            wake_load = 1'b1;
          end else begin
            state_d = sar_frame_pkg::ST_CONV;
            shreg_d = sample_in;
            smp_d = 1'b1;
            acq_d = 1'b0;
          end
        end
      end
      sar_frame_pkg::ST_CONV, sar_frame_pkg::ST_TAIL: begin
        if (sel_rise) begin
          oe_n_d = 1'b1;
          data_d = 1'b0;
          if (is_pd_window(edge_q)) begin
            state_d = sar_frame_pkg::ST_DOWN;
            acq_d = 1'b0;
          end else begin
            state_d = sar_frame_pkg::ST_IDLE;
            if (edge_q < 5'(ACQ_EDGE) || (edge_q == 5'(ACQ_EDGE) && !acq_q)) begin
              acq_d = 1'b0;
            end
          end
        end else begin
          if (sclk_fall) begin
            edge_d = edge_q + 5'h01;
            if (is_data_edge(edge_inc)) begin
              data_d = shreg_q[RES_BITS-1];
              shreg_d = {shreg_q[RES_BITS-2:0], 1'b0};
            end else begin
              data_d = 1'b0;
            end
            if (edge_q + 5'h01 == 5'(ACQ_EDGE)) begin
              acq_pend_d = 1'b1;
            end
            if (edge_q + 5'h01 == 5'(CONV_END_EDGE)) begin
              valid_d = 1'b1;
              state_d = sar_frame_pkg::ST_TAIL;
            end
            if (edge_q + 5'h01 == 5'(sar_frame_pkg::FRAME_EDGES)) begin
              oe_n_d = 1'b1;
              state_d = sar_frame_pkg::ST_IDLE;
            end
          end
          if (sclk_rise && acq_pend_q) begin
            acq_d = 1'b1;
            acq_pend_d = 1'b0;
          end
        end
      end
      sar_frame_pkg::ST_WAKE: begin
        if (sclk_fall && edge_q != 5'h1f) begin
          edge_d = edge_q + 5'h01;
        end
        if (sel_rise || (sclk_fall && edge_q + 5'h01 >= 5'(sar_frame_pkg::FRAME_EDGES))) begin
          oe_n_d = 1'b1;
          // more than ten falling edges wakes, else stay down
          state_d = is_wake_count(edge_q) ?
                    sar_frame_pkg::ST_IDLE : sar_frame_pkg::ST_DOWN;
        end
      end
      default: begin
        state_d = sar_frame_pkg::ST_IDLE;
        oe_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= sar_frame_pkg::ST_IDLE;
      edge_q <= sar_frame_pkg::EDGE_CNT_RESET;
      shreg_q <= '0;
      valid_q <= 1'b0;
      acq_q <= 1'b1;
      acq_pend_q <= 1'b0;
      data_q <= 1'b0;
      oe_n_q <= 1'b1;
      smp_q <= 1'b0;
    end else begin
      state_q <= state_d;
      edge_q <= edge_d;
      shreg_q <= shreg_d;
      valid_q <= valid_d;
      acq_q <= acq_d;
      acq_pend_q <= acq_pend_d;
      data_q <= data_d;
      oe_n_q <= oe_n_d;
      smp_q <= smp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake timer

  // counts down the power-up time once a wake frame has started
  always_comb begin
    wake_d = (wake_q != 16'h0000) ? wake_q - 16'h0001 : 16'h0000;
    if (wake_load) begin
      wake_d = 16'(WAKE_CYCLES);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_q <= 16'h0000;
    end else begin
      wake_q <= wake_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result capture

  // snapshot taken at the select fall, held until the next conversion
  always_comb begin
    res_d = res_q;
    if (smp_d) begin
      res_d = sample_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      res_q <= '0;
    end else begin
      res_q <= res_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    serial_result_out.data = data_q;
    serial_result_out.oe_n = oe_n_q;
    result_out = res_q;
    result_valid_out = valid_q;
    sample_out = smp_q;
    acquiring_out = acq_q;
    powered_down_out = is_down(state_q);
    ready_out = !is_down(state_q) && (wake_q == 16'h0000);
  end

endmodule : sar_adc_serial_frame_control

//--- bench/sar_frame_monitor.sv
// frame control port checker
// assumes host pins synchronous to clk_in
module sar_frame_monitor #(
  parameter int unsigned RES_BITS = 10
) (
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // reset
  input wire sar_frame_pkg::host_pins_t host_in, // host
  input wire sar_frame_pkg::serial_pin_t serial_result_out, // pin
  input wire logic [RES_BITS-1:0] result_out, // result
  input wire logic result_valid_out, // valid
  input wire logic sample_out, // sampled
  input wire logic acquiring_out, // acquire
  input wire logic powered_down_out // down
);
  localparam logic [4:0] LAST = 5'(RES_BITS + 3);
  logic sel_n, oe_n, dat, pd, sck, fall, sck_q;
  logic [4:0] cnt_q, cnt_d;
  assign sel_n = host_in.frame_sel_n;
  assign sck = host_in.shift_clk;
  assign oe_n = serial_result_out.oe_n;
  assign dat = serial_result_out.data;
  assign pd = powered_down_out;
  assign fall = !sel_n && sck_q && !sck;
  always_comb begin
    cnt_d = fall ? cnt_q + 5'h01 : cnt_q;
    if (sel_n) cnt_d = 5'h00;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sck_q <= 1'b1;
      cnt_q <= 5'h00;
    end else begin
      sck_q <= sck;
      cnt_q <= cnt_d;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_start_sample: assert property ($fell(sel_n) && !pd |=> sample_out && !acquiring_out)
    else $error("no sample");
  a_first_zero: assert property ($fell(sel_n) |=> !oe_n && !dat)
    else $error("first bit");
  a_lead_zero: assert property (fall && cnt_q < 5'h03 |=> !dat)
    else $error("lead zero");
  a_msb_first: assert property (fall && cnt_q == 5'h03 && !pd |=> dat == result_out[RES_BITS-1])
    else $error("msb");
  a_conv_end: assert property (fall && cnt_q == LAST && !pd |=> result_valid_out)
    else $error("conv end");
  a_acq_start: assert property (!sel_n && !sck_q && sck && cnt_q == LAST && !pd |=> acquiring_out)
    else $error("acquire");
  a_tri_last: assert property (fall && cnt_q == 5'h0f |=> oe_n)
    else $error("tri last");
  a_abort_tri: assert property ($rose(sel_n) |=> oe_n)
    else $error("abort tri");
  a_pd_entry: assert property ($rose(sel_n) && cnt_q >= 5'h02 && cnt_q <= 5'h09 |=> pd)
    else $error("pd entry");
  c_full: cover property (fall && cnt_q == 5'h0f);
  c_down: cover property ($rose(pd));
  c_wake: cover property ($fell(pd));
endmodule : sar_frame_monitor

bind sar_adc_serial_frame_control sar_frame_monitor #(.RES_BITS(RES_BITS)) i_sar_frame_monitor (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .host_in(host_in),
  .serial_result_out(serial_result_out), .result_out(result_out),
  .result_valid_out(result_valid_out), .sample_out(sample_out),
  .acquiring_out(acquiring_out), .powered_down_out(powered_down_out));

//--- bench/sar_host_model.sv
// host serial port: one frame of nfall_in falls per go_in
// assumes nfall_in steady while busy_out
module sar_host_model (
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic go_in, // start
  input wire logic [4:0] nfall_in, // falls
  output sar_frame_pkg::host_pins_t host_out, // pins
  output logic busy_out // busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] t_q, end_w;
  assign end_w = {nfall_in, 2'b00};
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_out <= '1;
      busy_out <= 1'b0;
      t_q <= 7'h00;
    end else if (!busy_out) begin
      t_q <= 7'h00;
      busy_out <= go_in;
      host_out.frame_sel_n <= !go_in;
    end else begin
      t_q <= t_q + 7'h01;
      host_out.shift_clk <= ~t_q[1] | (t_q >= end_w);
      if (t_q > end_w) host_out.frame_sel_n <= 1'b1;
      if (t_q == end_w + 7'h05) busy_out <= 1'b0;
    end
  end
endmodule : sar_host_model

//--- bench/sar_adc_serial_frame_control_tb_top.sv
// testbench: host model frames against the 10-bit variant
// assumes the checker binds itself
module sar_adc_serial_frame_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, rst_n_in = 1'b0, go = 1'b0, sck_q = 1'b1;
  logic [4:0] nf = 5'h00;
  logic [9:0] smp = 10'h000, res;
  logic rv, so, aq, pd, rdy, busy;
  sar_frame_pkg::host_pins_t host;
  sar_frame_pkg::serial_pin_t ser;
  int seed = 32'h1cd0, mismatches = 0, tests_run = 0;
  logic q[$];
  initial forever #5 clk_in = ~clk_in;
  sar_host_model i_sar_host_model (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go),
    .nfall_in(nf), .host_out(host), .busy_out(busy));
  sar_adc_serial_frame_control #(.RES_BITS(10), .WAKE_CYCLES(4)) i_sar_adc_serial_frame_control (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .host_in(host), .sample_in(smp),
    .serial_result_out(ser), .result_out(res), .result_valid_out(rv), .sample_out(so),
    .acquiring_out(aq), .powered_down_out(pd), .ready_out(rdy));
  task conclude;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task chk(input string n, input logic [9:0] e, input logic [9:0] s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task frame(input int n, input logic z);
    logic [15:0] w;
    int k;
    @(posedge clk_in);
    go <= 1'b1;
    nf <= n[4:0];
    smp <= 10'($random(seed));
    @(posedge clk_in);
    go <= 1'b0;
    w = z ? 16'h0000 : {4'h0, smp, 2'b00};
    for (k = 0; k < n; k++) q.push_back(w[15-k]);
    for (k = 0; k < 300; k++) begin
      @(posedge clk_in);
      if (!busy) break;
    end
    if (k == 300) begin
      mismatches++;
      conclude();
    end
    chk("oe_n", 10'h001, {9'h000, ser.oe_n});
    chk("left", 10'h000, 10'(q.size()));
    if (n == 16 && !z) chk("res", smp, res);
  endtask : frame
  always @(posedge clk_in) begin
    sck_q <= host.shift_clk;
    if (!host.frame_sel_n && sck_q && !host.shift_clk && !ser.oe_n)
      chk("bit", {9'h000, q.pop_front()}, {9'h000, ser.data});
  end
  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) frame(16, 1'b0);
    frame(12, 1'b0);
    chk("pd", 10'h000, {9'h000, pd});
    frame(4, 1'b0);
    chk("pd", 10'h001, {9'h000, pd});
    frame(12, 1'b1);
    chk("pd", 10'h000, {9'h000, pd});
    chk("rdy", 10'h001, {9'h000, rdy});
    frame(16, 1'b0);
    conclude();
  end
endmodule : sar_adc_serial_frame_control_tb_top
